// File: verilog/rio_holding_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rio_holding_regs
  import rio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  // rotary dials, one decimal digit each
  input  wire logic [3:0]  dial_tens,
  input  wire logic [3:0]  dial_units,
  // decoded request from the serial framer
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_slave_id,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // answer to the framer
  output logic             rsp_valid,
  output logic [7:0]       rsp_func,
  output logic [7:0]       rsp_exc,
  output logic [15:0]      rsp_data,
  // request to be relayed over the radio
  output logic             relay_valid,
  // identity taken from the dials
  output logic [7:0]       slave_id,
  output logic             slave_id_ok,
  // process inputs
  input  wire logic        binary_in_one,
  input  wire logic        binary_in_two,
  input  wire logic        binary_in_three,
  input  wire logic        binary_in_four,
  input  wire logic [15:0] loop_current_in_one,
  input  wire logic [15:0] loop_current_in_three,
  input  wire logic [15:0] temperature_probe_in,
  input  wire logic [31:0] pulse_count_in,
  // process outputs
  output logic             binary_out_one,
  output logic             binary_out_two,
  output logic             sensor_supply_three,
  output logic             sensor_supply_four
);

  // identity ranges keep wired slaves apart from radio nodes
  // identity in the local range
  function automatic logic is_local_id(input logic [7:0] id);
    is_local_id = (id >= RIO_ID_MIN) && (id <= RIO_ID_LOCAL_MAX);
  endfunction

  // identity in the radio range
  function automatic logic is_radio_id(input logic [7:0] id);
    is_radio_id = (id >= RIO_ID_RADIO_MIN) && (id <= RIO_ID_MAX);
  endfunction

  // dial capture state
  logic [7:0]  id_r;        // captured identity
  logic        id_ok_r;     // captured identity is legal
  logic        id_taken_r;  // dials sampled since reset
  // answer and output registers
  logic        rsp_valid_r;
  logic [7:0]  rsp_func_r;
  logic [7:0]  rsp_exc_r;
  logic [15:0] rsp_data_r;
  logic        relay_r;
  logic        out1_r;
  logic        out2_r;
  logic        sup3_r;
  logic        sup4_r;
  logic [15:0] cnt_lower_r; // lower word held when the upper word is read

  // a digit above nine cannot come from a decimal dial and is refused
  // dial decode: tens times ten plus units
  wire [7:0] dial_id = ({4'h0, dial_tens} * RIO_DIGIT_WEIGHT) + {4'h0, dial_units};
  wire       dial_ok = (dial_tens <= RIO_DIGIT_MAX) && (dial_units <= RIO_DIGIT_MAX)
                       && (is_local_id(dial_id) || is_radio_id(dial_id));

  // request decode; nothing is taken before the dials have been read
  // local identities stay on the wire, remote ones go to the radio
  wire        hit      = req_valid && id_taken_r && id_ok_r
                         && (req_slave_id == id_r);
  wire        is_rd    = (req_func == RIO_FC_READ_HOLD);
  wire        is_wr    = (req_func == RIO_FC_WRITE_HOLD);
  wire [15:0] reg_num  = req_addr + RIO_REG_BASE;
  wire        wr_legal = (req_wdata <= RIO_SWITCH_MAX);
  wire        relay_nxt = req_valid && id_taken_r && !hit
                          && is_radio_id(req_slave_id);

  // unmapped numbers fall to the default branch and are refused with the address exception
  // register lookup: mapped, writable, read value
  logic        map_hit;
  logic        map_rw;
  logic [15:0] rd_val;

  // read selection by register number
  always_comb
  begin
    map_hit = 1'b1;
    map_rw  = 1'b0;
    rd_val  = RIO_DATA_RESET;
    case (reg_num)
      RIO_REG_BIN_IN_1:  rd_val = {15'h0000, binary_in_one};
      RIO_REG_BIN_IN_2:  rd_val = {15'h0000, binary_in_two};
      RIO_REG_BIN_IN_3:  rd_val = {15'h0000, binary_in_three};
      RIO_REG_BIN_IN_4:  rd_val = {15'h0000, binary_in_four};
      RIO_REG_LOOP_1:    rd_val = loop_current_in_one;
      RIO_REG_LOOP_3:    rd_val = loop_current_in_three;
      RIO_REG_TEMP:      rd_val = temperature_probe_in;
      RIO_REG_CNT_UPPER: rd_val = pulse_count_in[31:16];
      RIO_REG_CNT_LOWER: rd_val = cnt_lower_r;
      RIO_REG_BIN_OUT_1:
      begin
        map_rw = 1'b1;
        rd_val = {15'h0000, out1_r};
      end
      RIO_REG_BIN_OUT_2:
      begin
        map_rw = 1'b1;
        rd_val = {15'h0000, out2_r};
      end
      RIO_REG_SUPPLY_3:
      begin
        map_rw = 1'b1;
        rd_val = {15'h0000, sup3_r};
      end
      RIO_REG_SUPPLY_4:
      begin
        map_rw = 1'b1;
        rd_val = {15'h0000, sup4_r};
      end
      default:           map_hit = 1'b0;
    endcase
  end

  // exception for the current request, first match wins: function, then
  // address, then value; a refused request is answered but changes nothing
  wire [7:0] exc_nxt = (!is_rd && !is_wr)          ? RIO_EXC_FUNC :
                       (!map_hit || (is_wr && !map_rw)) ? RIO_EXC_ADDR :
                       (is_wr && !wr_legal)        ? RIO_EXC_VALUE : RIO_EXC_NONE;
  wire       wr_ok   = hit && is_wr && (exc_nxt == RIO_EXC_NONE);
  wire       rd_ok   = hit && is_rd && (exc_nxt == RIO_EXC_NONE);

  // dials sampled once, on the first edge after reset is released
  // the dials behave like straps: turning them later takes effect only
  // at the next reset, so a node never changes identity in mid-poll
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      id_r       <= 8'h00;
      id_ok_r    <= 1'b0;
      id_taken_r <= 1'b0;
    end
    else if (!id_taken_r)
    begin
      id_r       <= dial_id;
      id_ok_r    <= dial_ok;
      id_taken_r <= 1'b1;
    end
  end

  // answer register, one cycle after an accepted request
  // foreign requests leave the answer fields as they were
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rsp_valid_r <= 1'b0;
      rsp_func_r  <= 8'h00;
      rsp_exc_r   <= RIO_EXC_NONE;
      rsp_data_r  <= RIO_DATA_RESET;
      relay_r     <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= hit;
      relay_r     <= relay_nxt;
      if (hit)
      begin
        rsp_func_r <= req_func;
        rsp_exc_r  <= exc_nxt;
        rsp_data_r <= is_wr ? req_wdata : rd_val;
      end
    end
  end

  // lower counter word held on an upper word read, so the pair is coherent
  // the host reads the words in two requests; without the hold a carry
  // between them would tear the 32-bit count
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_lower_r <= RIO_DATA_RESET;
    else if (rd_ok && (reg_num == RIO_REG_CNT_UPPER))
      cnt_lower_r <= pulse_count_in[15:0];
  end

  // writable output registers
  // only bit 0 is kept; values above one are refused before they land
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      out1_r <= RIO_OUT_RESET;
      out2_r <= RIO_OUT_RESET;
      sup3_r <= RIO_OUT_RESET;
      sup4_r <= RIO_OUT_RESET;
    end
    else if (wr_ok)
    begin
      if (reg_num == RIO_REG_BIN_OUT_1)
        out1_r <= req_wdata[0];
      if (reg_num == RIO_REG_BIN_OUT_2)
        out2_r <= req_wdata[0];
      if (reg_num == RIO_REG_SUPPLY_3)
        sup3_r <= req_wdata[0];
      if (reg_num == RIO_REG_SUPPLY_4)
        sup4_r <= req_wdata[0];
    end
  end

  // port drive
  // every output comes straight from a flip-flop
  assign rsp_valid           = rsp_valid_r;
  assign rsp_func            = rsp_func_r;
  assign rsp_exc             = rsp_exc_r;
  assign rsp_data            = rsp_data_r;
  assign relay_valid         = relay_r;
  assign slave_id            = id_r;
  assign slave_id_ok         = id_ok_r;
  assign binary_out_one      = out1_r;
  assign binary_out_two      = out2_r;
  assign sensor_supply_three = sup3_r;
  assign sensor_supply_four  = sup4_r;

  // checks
  // all checks run on the one clock and stay quiet while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_id_range: assert property (slave_id_ok |-> (slave_id >= RIO_ID_MIN)
      && (slave_id <= RIO_ID_MAX))
    else $error("legal identity outside 1..60");

  chk_local_no_relay: assert property (req_valid && is_local_id(req_slave_id)
      |=> !relay_valid)
    else $error("local identity relayed");

  chk_relay_range: assert property (relay_valid |-> is_radio_id($past(req_slave_id)))
    else $error("relay outside radio range");

  chk_bad_function: assert property (hit && !is_rd && !is_wr
      |=> rsp_valid && (rsp_exc == RIO_EXC_FUNC))
    else $error("bad function not refused");

  chk_input_read: assert property (hit && is_rd && (req_addr == 16'h0000)
      |=> (rsp_exc == RIO_EXC_NONE) && (rsp_data == {15'h0000, $past(binary_in_one)}))
    else $error("discrete input 1 not at address 0");

  chk_loop_read: assert property (hit && is_rd && (reg_num == RIO_REG_LOOP_3)
      |=> rsp_data == $past(loop_current_in_three))
    else $error("loop current 3 mismatch");

  chk_temp_read: assert property (hit && is_rd && (reg_num == RIO_REG_TEMP)
      |=> rsp_data == $past(temperature_probe_in))
    else $error("temperature mismatch");

  chk_count_pair: assert property (rd_ok && (reg_num == RIO_REG_CNT_UPPER)
      ##1 !req_valid ##1 (hit && is_rd && (reg_num == RIO_REG_CNT_LOWER))
      |=> rsp_data == $past(pulse_count_in[15:0], 3))
    else $error("counter words not coherent");

  chk_output_write: assert property (wr_ok && (reg_num == RIO_REG_BIN_OUT_2)
      |=> binary_out_two == $past(req_wdata[0]))
    else $error("discrete output 2 not written");

  chk_supply_write: assert property (hit && is_wr && (reg_num == RIO_REG_SUPPLY_3)
      && (req_wdata > RIO_SWITCH_MAX) |=> $stable(sensor_supply_three)
      && (rsp_exc == RIO_EXC_VALUE))
    else $error("illegal supply value accepted");

  chk_foreign_ignored: assert property (req_valid && (req_slave_id != slave_id)
      |=> !rsp_valid)
    else $error("foreign request answered");

  // identity capture: decode, refusal of non-decimal digits, no later change
  chk_dial_decode: assert property (!id_taken_r
      |=> slave_id == (({4'h0, $past(dial_tens)} * RIO_DIGIT_WEIGHT)
      + {4'h0, $past(dial_units)}))
    else $error("identity not taken from the dials");

  chk_digit_refused: assert property (!id_taken_r
      && ((dial_tens > RIO_DIGIT_MAX) || (dial_units > RIO_DIGIT_MAX)) |=> !slave_id_ok)
    else $error("non-decimal dial digit accepted");

  chk_id_held: assert property (id_taken_r
      |=> $stable(slave_id) && $stable(slave_id_ok))
    else $error("identity changed after capture");

  // routing: own identity answered here, other radio identities relayed
  chk_own_answered: assert property (req_valid && id_taken_r && slave_id_ok
      && (req_slave_id == slave_id) |=> rsp_valid && !relay_valid)
    else $error("own request not answered");

  chk_remote_relayed: assert property (req_valid && id_taken_r
      && is_radio_id(req_slave_id) && (req_slave_id != slave_id) |=> relay_valid)
    else $error("remote request not relayed");

  // refusals and echoes
  chk_func_echo: assert property (hit |=> rsp_func == $past(req_func))
    else $error("function code not echoed");

  chk_unmapped_read: assert property (hit && is_rd && !map_hit
      |=> rsp_valid && (rsp_exc == RIO_EXC_ADDR))
    else $error("unmapped register not refused");

  chk_read_only: assert property (hit && is_wr && (reg_num == RIO_REG_BIN_IN_1)
      |=> (rsp_exc == RIO_EXC_ADDR) && $stable(binary_out_one) && $stable(binary_out_two))
    else $error("write to input register accepted");

  // further read values
  chk_input_two: assert property (hit && is_rd && (reg_num == RIO_REG_BIN_IN_2)
      |=> rsp_data == {15'h0000, $past(binary_in_two)})
    else $error("discrete input 2 mismatch");

  chk_input_four: assert property (hit && is_rd && (reg_num == RIO_REG_BIN_IN_4)
      |=> rsp_data == {15'h0000, $past(binary_in_four)})
    else $error("discrete input 4 mismatch");

  chk_loop_one: assert property (hit && is_rd && (reg_num == RIO_REG_LOOP_1)
      |=> rsp_data == $past(loop_current_in_one))
    else $error("loop current 1 mismatch");

  chk_count_upper: assert property (hit && is_rd && (reg_num == RIO_REG_CNT_UPPER)
      |=> rsp_data == $past(pulse_count_in[31:16]))
    else $error("counter upper word mismatch");

  // further writes
  chk_output_value: assert property (hit && is_wr && (reg_num == RIO_REG_BIN_OUT_1)
      && (req_wdata > RIO_SWITCH_MAX) |=> $stable(binary_out_one)
      && (rsp_exc == RIO_EXC_VALUE))
    else $error("illegal output value accepted");

  chk_supply_four: assert property (wr_ok && (reg_num == RIO_REG_SUPPLY_4)
      |=> sensor_supply_four == $past(req_wdata[0]))
    else $error("sensor supply 4 not written");

  chk_write_echo: assert property (wr_ok |=> rsp_data == $past(req_wdata))
    else $error("written value not echoed");

endmodule
`default_nettype wire

// File: verilog/rio_pkg.sv
`default_nettype none
package rio_pkg;
  // register numbers as listed; the wire address is one less
  localparam logic [15:0] RIO_REG_BIN_IN_1    = 16'h0001;
  localparam logic [15:0] RIO_REG_BIN_IN_2    = 16'h0002;
  localparam logic [15:0] RIO_REG_BIN_IN_3    = 16'h0003;
  localparam logic [15:0] RIO_REG_BIN_IN_4    = 16'h0004;
  localparam logic [15:0] RIO_REG_LOOP_1      = 16'h0005;
  localparam logic [15:0] RIO_REG_LOOP_3      = 16'h0007;
  localparam logic [15:0] RIO_REG_TEMP        = 16'h0008;
  localparam logic [15:0] RIO_REG_CNT_UPPER   = 16'h0009;
  localparam logic [15:0] RIO_REG_CNT_LOWER   = 16'h000A;
  localparam logic [15:0] RIO_REG_BIN_OUT_1   = 16'h01F5;
  localparam logic [15:0] RIO_REG_BIN_OUT_2   = 16'h01F6;
  localparam logic [15:0] RIO_REG_SUPPLY_3    = 16'h01F9;
  localparam logic [15:0] RIO_REG_SUPPLY_4    = 16'h01FA;
  // numbering of listed registers starts at one
  localparam logic [15:0] RIO_REG_BASE        = 16'h0001;
  // identity ranges
  localparam logic [7:0]  RIO_ID_MIN          = 8'h01;
  localparam logic [7:0]  RIO_ID_LOCAL_MAX    = 8'h0A;
  localparam logic [7:0]  RIO_ID_RADIO_MIN    = 8'h0B;
  localparam logic [7:0]  RIO_ID_MAX          = 8'h3C;
  localparam logic [3:0]  RIO_DIGIT_MAX       = 4'h9;
  localparam logic [7:0]  RIO_DIGIT_WEIGHT    = 8'h0A;
  // function codes
  localparam logic [7:0]  RIO_FC_READ_HOLD    = 8'h03;
  localparam logic [7:0]  RIO_FC_WRITE_HOLD   = 8'h06;
  // exception codes
  localparam logic [7:0]  RIO_EXC_NONE        = 8'h00;
  localparam logic [7:0]  RIO_EXC_FUNC        = 8'h01;
  localparam logic [7:0]  RIO_EXC_ADDR        = 8'h02;
  localparam logic [7:0]  RIO_EXC_VALUE       = 8'h03;
  // reset values and legal written maximum
  localparam logic        RIO_OUT_RESET       = 1'b0;
  localparam logic [15:0] RIO_DATA_RESET      = 16'h0000;
  localparam logic [15:0] RIO_SWITCH_MAX      = 16'h0001;
endpackage
`default_nettype wire

// File: verification/rio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rio_host_model
  import rio_pkg::*;
#(
  parameter int MAX_SLAVES = 50 // host polls no more slaves than this
)
(
  input  wire logic        clk,
  output logic             req_valid,
  output logic [7:0]       req_slave_id,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata
);
  // distinct identities addressed so far, held within the system limit
  logic [255:0] polled = '0;
  int           n_polled = 0;
  // idle bus: no request, fields hold no meaning
  initial
  begin
    req_valid    = 1'b0;
    req_slave_id = 8'hA5;
    req_func     = 8'h5A;
    req_addr     = 16'hA5A5;
    req_wdata    = 16'h5A5A;
  end
  // one request: raised after an edge, held over the taking edge, then dropped
  task automatic xfer(input logic [7:0] id, input logic [7:0] fc,
                      input logic [15:0] rn, input logic [15:0] wd);
    if (!polled[id])
    begin
      polled[id] = 1'b1;
      n_polled++;                      // slaves counted against the limit
    end
    @(posedge clk);
    #2;
    req_valid    = 1'b1;
    req_slave_id = id;                 // remote nodes addressed in 11..60
    req_func     = fc;                 // holding-register functions
    req_addr     = rn - RIO_REG_BASE;  // wire address one below the number
    req_wdata    = wd;
    @(posedge clk);
    #2;
    req_valid    = 1'b0;
    // released fields show the inverse, never the stale value
    req_slave_id = ~id;
    req_func     = ~fc;
    req_addr     = ~req_addr;
    req_wdata    = ~wd;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_radio_io_holding_register_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_radio_io_holding_register_map
  import rio_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0;
  logic [3:0]  tens = 4'h1, units = 4'h5; // dial digits
  logic [3:0]  din = 4'h0;                // discrete inputs
  logic [15:0] l1 = 16'h0, l3 = 16'h0, tp = 16'h0, lat = 16'h0;
  logic [31:0] pc = 32'h0;                // event count
  logic [15:0] outs [4];                  // model of 501, 502, 505, 506
  logic        req_valid, rsp_valid, relay_valid, slave_id_ok;
  logic [7:0]  req_slave_id, req_func, rsp_func, rsp_exc, slave_id, my_id;
  logic [15:0] req_addr, req_wdata, rsp_data;
  logic        bo1, bo2, ss3, ss4;
  int          errors = 0, tests_run = 0, cyc = 0;
  rio_host_model i_host (.clk(clk), .req_valid(req_valid), .req_slave_id(req_slave_id),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata));
  rio_holding_regs i_dut (.clk(clk), .rstn(rstn), .dial_tens(tens), .dial_units(units),
    .req_valid(req_valid), .req_slave_id(req_slave_id), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
    .rsp_exc(rsp_exc), .rsp_data(rsp_data), .relay_valid(relay_valid), .slave_id(slave_id),
    .slave_id_ok(slave_id_ok), .binary_in_one(din[0]), .binary_in_two(din[1]),
    .binary_in_three(din[2]), .binary_in_four(din[3]), .loop_current_in_one(l1),
    .loop_current_in_three(l3), .temperature_probe_in(tp), .pulse_count_in(pc),
    .binary_out_one(bo1), .binary_out_two(bo2), .sensor_supply_three(ss3),
    .sensor_supply_four(ss4));
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      end_sim();
    end
  end
  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset for two cycles, model outputs cleared, identity from dials
  task automatic do_reset();
    @(posedge clk);
    #2;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rstn = 1'b1;
    foreach (outs[i]) outs[i] = 16'h0000;
    lat = 16'h0000;
    my_id = 8'(tens * 10 + units);
    @(posedge clk);
    #2;
  endtask
  // new random process inputs
  task automatic rnd();
    din = 4'($urandom);
    l1 = 16'($urandom);
    l3 = 16'($urandom);
    tp = 16'($urandom);
    pc = $urandom;
  endtask
  // one request through the host, checked against the model
  task automatic op(input logic [7:0] id, input logic [7:0] fc, input logic [15:0] rn,
                    input logic [15:0] wd);
    int          exc;
    int          oi;
    logic [15:0] ed;
    exc = 0;
    oi = -1;
    ed = wd;
    case (rn)
      501: oi = 0;
      502: oi = 1;
      505: oi = 2;
      506: oi = 3;
      default: oi = -1;
    endcase
    i_host.xfer(id, fc, rn, wd);
    if (id != my_id)
    begin
      chk(rsp_valid, 0);
      chk(relay_valid, (id >= 11 && id <= 60) ? 1 : 0);
      return;
    end
    if (fc == RIO_FC_READ_HOLD)
    begin
      if (oi >= 0) ed = outs[oi];
      else if (rn >= 1 && rn <= 4) ed = 16'(din[rn-1]);
      else if (rn == 5) ed = l1;
      else if (rn == 7) ed = l3;
      else if (rn == 8) ed = tp;
      else if (rn == 9)
      begin
        ed = pc[31:16];
        lat = pc[15:0];
      end
      else if (rn == 10) ed = lat;
      else exc = 2;
    end
    else if (fc == RIO_FC_WRITE_HOLD)
    begin
      if (oi < 0) exc = 2;
      else if (wd > 1) exc = 3;
      else outs[oi] = wd;
    end
    else exc = 1;
    chk(rsp_valid, 1);
    chk(relay_valid, 0);
    chk(rsp_exc, exc);
    if (exc == 0) chk({rsp_func, rsp_data}, {fc, ed});
    chk({bo1, bo2, ss3, ss4}, {outs[0][0], outs[1][0], outs[2][0], outs[3][0]});
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h677ED162));
    do_reset();
    chk({slave_id_ok, slave_id}, {1'b1, my_id});
    chk({bo1, bo2, ss3, ss4}, 0);
    // every readable input register, counter split across an input change
    repeat (4)
    begin
      rnd();
      for (int r = 1; r <= 10; r++)
      begin
        op(my_id, RIO_FC_READ_HOLD, 16'(r), 16'h0000);
        if (r == 9) pc = $urandom;
      end
    end
    // outputs on, bad value, read back; then output 502 back off
    for (int k = 0; k < 4; k++)
    begin
      op(my_id, RIO_FC_WRITE_HOLD, (k < 2) ? 16'(501 + k) : 16'(503 + k), 16'h0001);
      op(my_id, RIO_FC_WRITE_HOLD, (k < 2) ? 16'(501 + k) : 16'(503 + k), 16'h0002);
      op(my_id, RIO_FC_READ_HOLD, (k < 2) ? 16'(501 + k) : 16'(503 + k), 16'h0000);
    end
    op(my_id, RIO_FC_WRITE_HOLD, 16'd502, 16'h0000);
    // refusals: unmapped, read-only, unknown function
    op(my_id, RIO_FC_READ_HOLD, 16'd6, 16'h0000);
    op(my_id, RIO_FC_READ_HOLD, 16'd503, 16'h0000);
    op(my_id, RIO_FC_WRITE_HOLD, 16'd1, 16'h0001);
    op(my_id, 8'h10, 16'd501, 16'h0000);
    // other identities: local, radio bounds, out of range
    op(8'h00, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    op(8'h05, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    op(8'h0A, RIO_FC_WRITE_HOLD, 16'd501, 16'h0000);
    op(8'h0B, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    op(8'h3C, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    op(8'h3D, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    // mid-run reset onto an illegal identity: outputs cleared, never answers
    tens = 4'h6;
    units = 4'h1;
    do_reset();
    chk({slave_id_ok, bo1, bo2, ss3, ss4}, 0);
    i_host.xfer(8'h3D, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    chk(rsp_valid, 0);
    // non-decimal digit: refused although twelve is a radio identity
    tens = 4'h0;
    units = 4'hC;
    do_reset();
    chk({slave_id_ok, slave_id}, {1'b0, 8'h0C});
    i_host.xfer(8'h0C, RIO_FC_READ_HOLD, 16'd1, 16'h0000);
    chk(rsp_valid, 0);
    chk(i_host.n_polled <= i_host.MAX_SLAVES, 1);
    end_sim();
  end
endmodule
`default_nettype wire
